// file: design/sslpc_defs.svh
`ifndef SSLPC_DEFS_SVH
`define SSLPC_DEFS_SVH

// programming word shape
`define SSLPC_WORD_W    24
`define SSLPC_CTRL_W    2
`define SSLPC_NUM_LATCH 4

// latch and bit that hold the power down bit
`define SSLPC_PD_LATCH  2'h2
`define SSLPC_PD_BIT    3

// monitor select field inside the same latch
`define SSLPC_MON_LSB   4
`define SSLPC_MON_W     3

// reset value of every latch
`define SSLPC_LATCH_RST 24'h000000

`endif

// file: design/sslpc_pkg.sv
`include "sslpc_defs.svh"

package sslpc_pkg;

  typedef logic [`SSLPC_WORD_W-1:0] sslpc_word_t;
  typedef logic [`SSLPC_CTRL_W-1:0] sslpc_ctrl_t;

  // monitor output sources
  typedef enum logic [`SSLPC_MON_W-1:0] {
    SSLPC_MON_LOCK = 3'h0,
    SSLPC_MON_RF   = 3'h1,
    SSLPC_MON_REF  = 3'h2
  } sslpc_mon_sel_t;

endpackage

// file: design/sslpc_shift_if.sv
`timescale 1ns/1ps

interface sslpc_shift_if;
  import sslpc_pkg::*;

  sslpc_word_t word;
  logic        load;

  modport src (output word, output load);
  modport dst (input  word, input  load);
endinterface

// file: design/sslpc_shifter.sv
`timescale 1ns/1ps
`include "sslpc_defs.svh"

module sslpc_shifter
  import sslpc_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   ser_clk,
  input  wire logic   ser_data,
  input  wire logic   load_strobe,
  sslpc_shift_if.src  sh
);

  logic        ser_clk_r;
  logic        ser_clk_nxt;
  logic        strobe_r;
  logic        strobe_nxt;
  sslpc_word_t shift_r;
  sslpc_word_t shift_nxt;
  logic        clk_rise;

  // edge detect on the sampled pins
  assign clk_rise = ser_clk & ~ser_clk_r;
  assign sh.load  = load_strobe & ~strobe_r; // one pulse per strobe rise
  assign sh.word  = shift_r;

  // shift one bit per serial clock rise, msb first
  always_comb begin
    ser_clk_nxt = ser_clk;
    strobe_nxt  = load_strobe;
    shift_nxt   = shift_r;
    if (clk_rise) begin
      shift_nxt = {shift_r[`SSLPC_WORD_W-2:0], ser_data};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ser_clk_r <= 1'b0;
      strobe_r  <= 1'b0;
      shift_r   <= `SSLPC_LATCH_RST;
    end else begin
      ser_clk_r <= ser_clk_nxt;
      strobe_r  <= strobe_nxt;
      shift_r   <= shift_nxt;
    end
  end

  property p_shift_in;
    @(posedge ref_clk) disable iff (rst)
      clk_rise |=> shift_r == {$past(shift_r[`SSLPC_WORD_W-2:0]), $past(ser_data)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

  property p_shift_hold;
    @(posedge ref_clk) disable iff (rst)
      !clk_rise |=> $stable(shift_r);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift moved without clock");

endmodule

// file: design/sslpc_top.sv
`timescale 1ns/1ps
`include "sslpc_defs.svh"

// Behaviour
// - Each rising serial clock edge shifts the data bit into a 24-bit shift register.
// - A rising load strobe copies the shift register into the latch its two low bits select.
// - A low chip enable powers the device down and floats the charge pump output.
// - A high chip enable powers up only while the programmed power down bit is clear.
// - The monitor output shows lock detect, divided rf or divided reference.
// - The charge pump sources or sinks only while enabled and is idle otherwise.
module sslpc_top
  import sslpc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic load_strobe,
  input  wire logic chip_enable,
  input  wire logic lock_detect,
  input  wire logic rf_div,
  input  wire logic ref_div,
  input  wire logic pump_up,
  input  wire logic pump_dn,
  output logic      selectable_monitor_output,
  output logic      charge_pump_source,
  output logic      charge_pump_sink,
  output logic      charge_pump_output_oe_n,
  output logic      powered_up
);

  sslpc_shift_if sh ();

  sslpc_shifter u_shifter (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ser_clk     (ser_clk),
    .ser_data    (ser_data),
    .load_strobe (load_strobe),
    .sh          (sh.src)
  );

  // true when a load strobe targets latch idx
  function automatic logic sel_hit(input logic ld, input sslpc_word_t w, input sslpc_ctrl_t idx);
    sel_hit = ld && (w[`SSLPC_CTRL_W-1:0] == idx);
  endfunction

  sslpc_word_t latch_r   [`SSLPC_NUM_LATCH];
  sslpc_word_t latch_nxt [`SSLPC_NUM_LATCH];

  // one latch per control code; only its own strobe may touch it
  for (genvar gi = 0; gi < `SSLPC_NUM_LATCH; gi++) begin : g_latch
    always_comb begin
      latch_nxt[gi] = latch_r[gi];
      if (sel_hit(sh.load, sh.word, sslpc_ctrl_t'(gi))) begin
        latch_nxt[gi] = sh.word;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        latch_r[gi] <= `SSLPC_LATCH_RST;
      end else begin
        latch_r[gi] <= latch_nxt[gi];
      end
    end
  end

  logic           pd_bit;
  sslpc_mon_sel_t mon_sel;
  logic           pwr_r;
  logic           pwr_nxt;
  logic           mon_r;
  logic           mon_nxt;
  logic           src_r;
  logic           src_nxt;
  logic           snk_r;
  logic           snk_nxt;

  assign pd_bit  = latch_r[`SSLPC_PD_LATCH][`SSLPC_PD_BIT];
  assign mon_sel = sslpc_mon_sel_t'(latch_r[`SSLPC_PD_LATCH][`SSLPC_MON_LSB +: `SSLPC_MON_W]);

  // power state, pump drive and monitor select; all registered so pins never glitch
  always_comb begin
    pwr_nxt = chip_enable & ~pd_bit;
    src_nxt = pwr_nxt & pump_up;
    snk_nxt = pwr_nxt & pump_dn;
    case (mon_sel)
      SSLPC_MON_LOCK: mon_nxt = lock_detect;
      SSLPC_MON_RF:   mon_nxt = rf_div;
      SSLPC_MON_REF:  mon_nxt = ref_div;
      default:        mon_nxt = 1'b0;        // unused codes park low
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_r <= 1'b0;
      mon_r <= 1'b0;
      src_r <= 1'b0;
      snk_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      mon_r <= mon_nxt;
      src_r <= src_nxt;
      snk_r <= snk_nxt;
    end
  end

  assign powered_up                = pwr_r;
  assign charge_pump_output_oe_n   = ~pwr_r; // floats while powered down
  assign charge_pump_source        = src_r;
  assign charge_pump_sink          = snk_r;
  assign selectable_monitor_output = mon_r;

  property p_load_copy;
    @(posedge ref_clk) disable iff (rst)
      sh.load |=> latch_r[$past(sh.word[`SSLPC_CTRL_W-1:0])] == $past(sh.word);
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not reach latch");

  property p_no_load_hold;
    @(posedge ref_clk) disable iff (rst)
      !sh.load |=> $stable(latch_r[0]) && $stable(latch_r[1]) &&
                   $stable(latch_r[2]) && $stable(latch_r[3]);
  endproperty
  a_no_load_hold: assert property (p_no_load_hold) else $error("latch changed without load");

  property p_ce_low_float;
    @(posedge ref_clk) disable iff (rst)
      !chip_enable |=> charge_pump_output_oe_n && !powered_up;
  endproperty
  a_ce_low_float: assert property (p_ce_low_float) else $error("pump driven with ce low");

  property p_power_up;
    @(posedge ref_clk) disable iff (rst)
      chip_enable |=> powered_up == !$past(pd_bit);
  endproperty
  a_power_up: assert property (p_power_up) else $error("power state ignores pd bit");

  property p_mon_rf;
    @(posedge ref_clk) disable iff (rst)
      mon_sel == SSLPC_MON_RF |=> selectable_monitor_output == $past(rf_div);
  endproperty
  a_mon_rf: assert property (p_mon_rf) else $error("monitor not showing rf");

  property p_mon_lock;
    @(posedge ref_clk) disable iff (rst)
      mon_sel == SSLPC_MON_LOCK |=> selectable_monitor_output == $past(lock_detect);
  endproperty
  a_mon_lock: assert property (p_mon_lock) else $error("monitor not showing lock");

  property p_pump_idle;
    @(posedge ref_clk) disable iff (rst)
      charge_pump_output_oe_n |-> !charge_pump_source && !charge_pump_sink;
  endproperty
  a_pump_idle: assert property (p_pump_idle) else $error("pump active while disabled");

  property p_pump_follow;
    @(posedge ref_clk) disable iff (rst)
      pwr_nxt |=> charge_pump_source == $past(pump_up) && charge_pump_sink == $past(pump_dn);
  endproperty
  a_pump_follow: assert property (p_pump_follow) else $error("pump ignores request");

  // the power down latch must ignore loads aimed at the other latches
  property p_load_only_sel;
    @(posedge ref_clk) disable iff (rst)
      sh.load && (sh.word[`SSLPC_CTRL_W-1:0] != `SSLPC_PD_LATCH) |=>
        $stable(latch_r[`SSLPC_PD_LATCH]);
  endproperty
  a_load_only_sel: assert property (p_load_only_sel) else $error("load hit wrong latch");

  // a strobe held high must not load a second time
  property p_load_once;
    @(posedge ref_clk) disable iff (rst)
      sh.load |=> !sh.load;
  endproperty
  a_load_once: assert property (p_load_once) else $error("strobe loaded twice");

  property p_pd_block;
    @(posedge ref_clk) disable iff (rst)
      chip_enable && pd_bit |=> !powered_up && charge_pump_output_oe_n;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("pd bit did not hold power off");

  property p_ce_rise_up;
    @(posedge ref_clk) disable iff (rst)
      $rose(chip_enable) && !pd_bit |=> powered_up && !charge_pump_output_oe_n;
  endproperty
  a_ce_rise_up: assert property (p_ce_rise_up) else $error("chip enable did not power up");

  property p_mon_ref;
    @(posedge ref_clk) disable iff (rst)
      mon_sel == SSLPC_MON_REF |=> selectable_monitor_output == $past(ref_div);
  endproperty
  a_mon_ref: assert property (p_mon_ref) else $error("monitor not showing ref");

  // unused select codes must park the pin rather than leak a source
  property p_mon_park;
    @(posedge ref_clk) disable iff (rst)
      !(mon_sel inside {SSLPC_MON_LOCK, SSLPC_MON_RF, SSLPC_MON_REF}) |=> !selectable_monitor_output;
  endproperty
  a_mon_park: assert property (p_mon_park) else $error("monitor not parked low");

  // no reset disable here: this one watches the reset itself
  property p_reset_idle;
    @(posedge ref_clk)
      rst |=> !powered_up && charge_pump_output_oe_n && !charge_pump_source &&
              !charge_pump_sink && !selectable_monitor_output;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");

  c_load_pd: cover property (@(posedge ref_clk) disable iff (rst)
    sel_hit(sh.load, sh.word, `SSLPC_PD_LATCH));
  c_load_l0: cover property (@(posedge ref_clk) disable iff (rst)
    sel_hit(sh.load, sh.word, 2'h0));
  c_powerup: cover property (@(posedge ref_clk) disable iff (rst) $rose(powered_up));
  c_mon_ref: cover property (@(posedge ref_clk) disable iff (rst) mon_sel == SSLPC_MON_REF);
  c_pd_block: cover property (@(posedge ref_clk) disable iff (rst)
    chip_enable && pd_bit);

endmodule

// file: testbench/sslpc_host.sv
`timescale 1ns/1ps

module sslpc_host
  import sslpc_pkg::*;
(
  ref_clk,
  ser_clk,
  ser_data,
  load_strobe
);
  input  wire logic ref_clk;
  output logic      ser_clk;
  output logic      ser_data;
  output logic      load_strobe;

  // serial clock stands low outside frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end

  // one word msb first, clock high two cycles and low three per bit; strobe optional
  task automatic send_word(input sslpc_word_t w, input logic load);
    for (int i = $bits(sslpc_word_t) - 1; i >= 0; i--) begin
      @(negedge ref_clk);
      ser_data = w[i];
      repeat (2) @(negedge ref_clk);
      ser_clk = 1'b1;
      repeat (2) @(negedge ref_clk);
      ser_clk = 1'b0;
    end
    // released data line flips so a stale bit cannot pass
    ser_data = ~w[0];
    repeat (2) @(negedge ref_clk);
    load_strobe = load;
    repeat (2) @(negedge ref_clk);
    load_strobe = 1'b0;
  endtask
endmodule

// file: testbench/tb_sslpc_top.sv
`timescale 1ns/1ps

module tb_sslpc_top
  import sslpc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_enable = 1'b0;
  logic lock_detect = 1'b0;
  logic rf_div = 1'b0;
  logic ref_div = 1'b0;
  logic pump_up = 1'b0;
  logic pump_dn = 1'b0;
  logic ser_clk, ser_data, load_strobe;
  logic mon, src, snk, oe_n, pwr;
  int   err_count = 0;
  int   n_tests = 0;

  // 200 MHz system clock
  always #2.5 ref_clk = ~ref_clk;

  sslpc_host host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
                   .load_strobe(load_strobe));

  sslpc_top DUT (.ref_clk(ref_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe), .chip_enable(chip_enable), .lock_detect(lock_detect),
    .rf_div(rf_div), .ref_div(ref_div), .pump_up(pump_up), .pump_dn(pump_dn),
    .selectable_monitor_output(mon), .charge_pump_source(src), .charge_pump_sink(snk),
    .charge_pump_output_oe_n(oe_n), .powered_up(pwr));

  task automatic check_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  // outputs lag inputs by a cycle, loads by two: four is ample
  task automatic check_pins(input logic p, input logic s, input logic k);
    repeat (4) @(negedge ref_clk);
    check_bit("powered_up", p, pwr);
    check_bit("oe_n", ~p, oe_n);
    check_bit("source", s, src);
    check_bit("sink", k, snk);
  endtask

  task automatic test_power();
    check_pins(1'b0, 1'b0, 1'b0);
    chip_enable = 1'b1;
    pump_up = 1'b1;
    check_pins(1'b1, 1'b1, 1'b0);
    pump_up = 1'b0;
    pump_dn = 1'b1;
    check_pins(1'b1, 1'b0, 1'b1);
    chip_enable = 1'b0;
    check_pins(1'b0, 1'b0, 1'b0);
    pump_dn = 1'b0;
    $display("test power done");
  endtask

  // power down bit sits in latch 2 only; other indexes must not touch it
  task automatic test_latch();
    chip_enable = 1'b1;
    host.send_word(24'h00000A, 1'b1);
    check_pins(1'b0, 1'b0, 1'b0);
    host.send_word(24'h000002, 1'b1);
    check_pins(1'b1, 1'b0, 1'b0);
    host.send_word(24'h000008, 1'b1);
    host.send_word(24'h000009, 1'b1);
    host.send_word(24'h00000B, 1'b1);
    check_pins(1'b1, 1'b0, 1'b0);
    host.send_word(24'h00000A, 1'b0);
    check_pins(1'b1, 1'b0, 1'b0);
    host.send_word(24'hFFFF0A, 1'b1);
    check_pins(1'b0, 1'b0, 1'b0);
    $display("test latch done");
  endtask

  task automatic test_monitor();
    logic [2:0] pat;
    for (int s = 0; s < 4; s++) begin
      host.send_word(sslpc_word_t'(s << 4) | 24'h000002, 1'b1);
      for (int p = 1; p < 7; p++) begin
        pat = 3'(p);
        {lock_detect, rf_div, ref_div} = pat;
        repeat (4) @(negedge ref_clk);
        check_bit("monitor", (s < 3) ? pat[2 - s] : 1'b0, mon);
      end
    end
    $display("test monitor done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // about 1500 cycles expected; cut off well beyond
  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    test_power();
    test_latch();
    test_monitor();
    complete_run();
  end
endmodule
